// ### intelligent_terminal_register_set_tb_top.sv
// Self-checking bench of the register set with two channels.
// Assumes the coupler model as sole bus master and parity pulses from here.
`timescale 1ns/1ps
module intelligent_terminal_register_set_tb_top;
    localparam logic [15:0] KIND = 16'h1357; // Arbitrary identifier value.
    localparam logic [15:0] FWV = 16'h3132;
    localparam logic [15:0] SRL = 16'h0108;
    localparam logic [15:0] SIG = 16'h0003;
    localparam logic [15:0] MINL = 16'h8003;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [1:0] parity_err = 2'b00;
    logic [9:0] address;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic waitreq;
    logic [1:0] busy;
    logic irq;
    logic [31:0] got;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 i_core_clk = ~i_core_clk;
    itr_regs #(.NCH(2), .TERM_KIND(KIND), .FW_VERSION(FWV), .SR_LEN(SRL), .SIG_CH(SIG),
        .MIN_LEN(MINL), .DATA_TYPE(itr_pkg::ITR_DT_BYTES)) uut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_avs_address(address),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_parity_err(parity_err), .o_chan_busy(busy), .o_irq(irq));
    itr_cpl_model #(.AW(10)) cpl (
        .i_core_clk(i_core_clk), .i_waitrequest(waitreq), .i_readdata(rdata),
        .o_address(address), .o_read(rd_en), .o_write(wr_en), .o_writedata(wdata),
        .o_byteenable(be));
    function automatic logic [9:0] ca(input int ch, input logic [5:0] w);
        return {1'b0, ch[0], w, 2'b00};
    endfunction : ca
    function automatic logic [9:0] ga(input logic [5:0] w);
        return {2'b10, w, 2'b00};
    endfunction : ga
    task automatic give_verdict();
        $display("Checks %0d, failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        cpl.rd(a, got);
        chk(got, exp);
    endtask : rdc
    // Busy rises one edge after the write; the loop bound outlasts any run.
    task automatic wait_idle(input int ch);
        @(posedge i_core_clk);
        for (int k = 0; k < 20 && busy[ch] !== 1'b0; k++) begin
            @(posedge i_core_clk);
        end
        chk({31'h0, busy[ch]}, 32'h0);
    endtask : wait_idle
    task automatic run_cmd(input int ch, input logic [15:0] cmd);
        cpl.wr(ca(ch, 6'h07), {16'h0000, cmd}, 4'h3);
        wait_idle(ch);
    endtask : run_cmd
    // ********
    // Scenarios
    // ********
    task automatic t_reset_map();
        logic [5:0] zw[7] = '{6'h0E, 6'h10, 6'h1F, 6'h20, 6'h2F, 6'h30, 6'h3F};
        logic [15:0] tv[6] = '{KIND, FWV, SRL, SIG, MINL, 16'h0001};
        for (int w = 0; w < 8; w++) rdc(ca(1, w[5:0]), 32'h0);
        for (int i = 0; i < 7; i++) rdc(ca(0, zw[i]), 32'h0);
        for (int i = 0; i < 6; i++) begin
            cpl.wr(ca(0, 6'h08 + i[5:0]), 32'hFFFFFFFF, 4'hF);
            rdc(ca(0, 6'h08 + i[5:0]), {16'h0000, tv[i]});
        end
        cpl.wr(ca(0, 6'h14), 32'h0000FFFF, 4'hF);
        rdc(ca(0, 6'h14), 32'h0);
    endtask : t_reset_map
    task automatic t_ram();
        cpl.wr(ca(0, 6'h00), 32'h00001234, 4'h3);
        cpl.wr(ca(1, 6'h00), 32'h0000ABCD, 4'h3);
        cpl.wr(ca(0, 6'h05), 32'h00FF0055, 4'h1);
        cpl.wr(ca(1, 6'h0F), 32'h0000BEEF, 4'h3);
        rdc(ca(0, 6'h00), 32'h00001234);
        rdc(ca(1, 6'h00), 32'h0000ABCD);
        rdc(ca(0, 6'h05), 32'h00000055);
        rdc(ca(1, 6'h0F), 32'h0000BEEF);
    endtask : t_ram
    task automatic t_command();
        cpl.wr(ga(6'h01), 32'h0000000F, 4'hF);
        rdc(ga(6'h01), 32'h0000000F);
        cpl.wr(ca(0, 6'h07), 32'h00000155, 4'h3);
        rdc(ca(0, 6'h07), 32'h00000000);
        wait_idle(0);
        rdc(ca(0, 6'h07), 32'h00000155);
        chk({31'h0, irq}, 32'h1);
        rdc(ga(6'h00), 32'h00000004);
        cpl.wr(ga(6'h02), 32'h00000004, 4'hF);
        repeat (2) @(posedge i_core_clk);
        chk({31'h0, irq}, 32'h0);
        cpl.wr(ca(0, 6'h07), 32'h00007A11, 4'h3);
        cpl.wr(ca(0, 6'h07), 32'h00000199, 4'h3);
        wait_idle(0);
        rdc(ca(0, 6'h07), 32'h00007AFF);
        run_cmd(0, 16'h0033);
        rdc(ca(0, 6'h07), 32'h00000000);
    endtask : t_command
    task automatic t_parity();
        cpl.wr(ga(6'h02), 32'h0000000F, 4'hF);
        @(posedge i_core_clk);
        parity_err <= 2'b10;
        @(posedge i_core_clk);
        parity_err <= 2'b00;
        rdc(ca(1, 6'h06), 32'h00000001);
        rdc(ca(0, 6'h06), 32'h00000000);
        chk({31'h0, irq}, 32'h1);
        cpl.wr(ca(1, 6'h06), 32'h00000000, 4'h3);
        rdc(ca(1, 6'h06), 32'h00000001);
        run_cmd(1, 16'h0200);
        rdc(ca(1, 6'h07), 32'h00000200);
        rdc(ca(1, 6'h06), 32'h00000000);
        rdc(ga(6'h00), 32'h0000000A);
    endtask : t_parity
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        t_reset_map();
        t_ram();
        t_command();
        t_parity();
        give_verdict();
    end
endmodule : intelligent_terminal_register_set_tb_top

// ### itr_cpl_model.sv
// Bus coupler model: an Avalon-MM master issuing single word transfers.
// Assumes a slave that eventually drops waitrequest; the bench timeout covers hangs.
`timescale 1ns/1ps
module itr_cpl_model #(
    parameter int unsigned AW = 10
) (
    input wire logic i_core_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [AW-1:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    initial begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h00000000;
        o_byteenable = 4'h0;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge i_core_clk);
        o_address <= a;
        o_writedata <= d;
        o_byteenable <= be;
        o_write <= 1'b1;
        @(posedge i_core_clk);
        while (i_waitrequest !== 1'b0) begin
            @(posedge i_core_clk);
        end
        o_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        o_address <= a;
        o_read <= 1'b1;
        @(posedge i_core_clk);
        while (i_waitrequest !== 1'b0) begin
            @(posedge i_core_clk);
        end
        d = i_readdata;
        o_read <= 1'b0;
    endtask : rd
endmodule : itr_cpl_model

// ### itr_defines.svh
// Offsets, field positions, reset values and timing counts of the
// intelligent terminal register set.
// Assumes inclusion by bare name; definitions only.
`ifndef ITR_DEFINES_SVH
`define ITR_DEFINES_SVH

// ********************************************************************
// Register set geometry (word index within one channel's set)
// ********************************************************************
`define ITR_IDX_W 6
`define ITR_WORDS 64
`define ITR_PV_LAST 6'h05
`define ITR_DIAG 6'h06
`define ITR_CMD 6'h07
`define ITR_KIND 6'h08
`define ITR_FWVER 6'h09
`define ITR_SRLEN 6'h0A
`define ITR_SIGCH 6'h0B
`define ITR_MINLEN 6'h0C
`define ITR_DTYPE 6'h0D
`define ITR_SPARE 6'h0E
`define ITR_ALIGN 6'h0F
`define ITR_MFR_FIRST 6'h10
`define ITR_USR_FIRST 6'h20
`define ITR_EXT_FIRST 6'h30

// ********************************************************************
// Block-level registers, reached with the global select bit set
// ********************************************************************
`define ITR_G_STATUS 6'h00
`define ITR_G_ENABLE 6'h01
`define ITR_G_CLEAR 6'h02

// ********************************************************************
// Fields, reset values and timing
// ********************************************************************
`define ITR_DIAG_PARITY 0
`define ITR_RESULT_BAD 8'hFF
`define ITR_FUNC_CYCLES 4
`define ITR_KIND_DEF 16'h0A5C
`define ITR_FWVER_DEF 16'h3130
`define ITR_SRLEN_DEF 16'h0000
`define ITR_SIGCH_DEF 16'h0001
`define ITR_MINLEN_DEF 16'h0000

`endif

// ### itr_func.sv
// Function executor of one channel's command register.
// Assumes a start pulse only while o_busy is low.
`timescale 1ns/1ps
`include "itr_defines.svh"

module itr_func #(
    parameter int unsigned CYCLES = `ITR_FUNC_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic [7:0] i_fnum,
    input wire logic [7:0] i_param,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_result,
    output logic o_clr_diag
);

    typedef struct packed {
        itr_pkg::itr_fstate_t st;
        logic busy;
        logic [7:0] cnt;
        logic [7:0] fnum;
        logic [7:0] param;
        logic [7:0] result;
        logic done;
        logic clr;
    } itr_fstate_reg_t;

    itr_fstate_reg_t q;
    itr_fstate_reg_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.clr = 1'b0;
        case (q.st)
            itr_pkg::ITR_F_IDLE: begin
                if (i_start) begin
                    d.st = itr_pkg::ITR_F_RUN;
                    d.busy = 1'b1;
                    d.cnt = 8'(CYCLES - 1);
                    d.fnum = i_fnum;
                    d.param = i_param;
                end
            end
            itr_pkg::ITR_F_RUN: begin
                if (q.cnt == 8'h00) begin
                    d.st = itr_pkg::ITR_F_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    case (q.fnum)
                        itr_pkg::ITR_FN_NOP: d.result = 8'h00;
                        itr_pkg::ITR_FN_ECHO: d.result = q.param;
                        itr_pkg::ITR_FN_CLR_DIAG: begin
                            d.result = 8'h00;
                            d.clr = 1'b1;
                        end
                        default: d.result = `ITR_RESULT_BAD;
                    endcase
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            default: begin
                d.st = itr_pkg::ITR_F_IDLE;
                d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_busy = q.busy;
    assign o_done = q.done;
    assign o_result = q.result;
    assign o_clr_diag = q.clr;

endmodule : itr_func

// ### itr_pkg.sv
// Types shared by the intelligent terminal register set.
// Assumes nothing of its surroundings.
package itr_pkg;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [7:0] {
        ITR_DT_NONE = 8'h00,
        ITR_DT_BYTES = 8'h01,
        ITR_DT_BYTE_N = 8'h02
    } itr_dtype_t;

    typedef enum logic [7:0] {
        ITR_FN_NOP = 8'h00,
        ITR_FN_ECHO = 8'h01,
        ITR_FN_CLR_DIAG = 8'h02
    } itr_fn_t;

    typedef enum logic [1:0] {
        ITR_F_IDLE,
        ITR_F_RUN
    } itr_fstate_t;

    // ****************************************************************
    // One channel's writable and volatile words
    // ****************************************************************
    typedef struct packed {
        logic [5:0][15:0] pv;
        logic [15:0] align;
        logic [15:0] diag;
        logic [7:0] cmd_param;
        logic [7:0] cmd_fnum;
        logic [7:0] cmd_result;
        logic cmd_done;
    } itr_chan_t;

endpackage : itr_pkg

// ### itr_regs.sv
// Register sets of an intelligent serial terminal, one per channel,
// behind an Avalon-MM slave with waitrequest.
// Assumes a byte-addressed master that holds its request until it
// samples waitrequest low, and parity error pulses from the serial side.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "itr_defines.svh"

module itr_regs #(
    parameter int unsigned NCH = 1,
    parameter int unsigned CHW = (NCH > 1) ? $clog2(NCH) : 1,
    parameter logic [15:0] TERM_KIND = `ITR_KIND_DEF,
    parameter logic [15:0] FW_VERSION = `ITR_FWVER_DEF,
    parameter logic [15:0] SR_LEN = `ITR_SRLEN_DEF,
    parameter logic [15:0] SIG_CH = `ITR_SIGCH_DEF,
    parameter logic [15:0] MIN_LEN = `ITR_MINLEN_DEF,
    parameter itr_pkg::itr_dtype_t DATA_TYPE = itr_pkg::ITR_DT_BYTE_N,
    parameter int unsigned FUNC_CYCLES = `ITR_FUNC_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [CHW+8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [NCH-1:0] i_parity_err,
    output logic [NCH-1:0] o_chan_busy,
    output logic o_irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    // Interrupt bits: low half parity events, high half function done.
    localparam int unsigned IW = 2 * NCH;

    typedef struct packed {
        itr_pkg::itr_chan_t [NCH-1:0] ch;
        logic [IW-1:0] irq_sts;
        logic [IW-1:0] irq_en;
        logic irq;
        logic wait_r;
        logic [NCH-1:0] busy;
        logic [31:0] rdata;
    } itr_state_t;

    itr_state_t q;
    itr_state_t d;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Byte address: [7:2] word index, then channel, then global select.
    logic [5:0] idx;
    logic [CHW-1:0] chs;
    logic glob;
    logic chan_ok;
    logic req;
    logic rd_done;
    logic wr_done;

    assign idx = i_avs_address[7:2];
    assign chs = i_avs_address[CHW+7:8];
    assign glob = i_avs_address[CHW+8];
    assign chan_ok = ({1'b0, chs} < (CHW + 1)'(NCH));
    assign req = i_avs_read | i_avs_write;
    // A transfer completes at the edge where waitrequest is seen low.
    assign rd_done = i_avs_read & ~q.wait_r;
    assign wr_done = i_avs_write & ~q.wait_r;

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // ****************************************************************
    // Function executors, one per channel
    // ****************************************************************
    logic [NCH-1:0] f_start;
    logic [NCH-1:0] f_busy;
    logic [NCH-1:0] f_done;
    logic [NCH-1:0] f_clr;
    logic [NCH-1:0][7:0] f_res;
    logic [NCH-1:0][7:0] f_param;

    always_comb begin
        f_start = '0;
        f_param = '0;
        for (int c = 0; c < NCH; c++) begin
            // A new parameter written together with the number is used.
            f_param[c] = i_avs_byteenable[0] ? i_avs_writedata[7:0]
                                             : q.ch[c].cmd_param;
            if (wr_done && !glob && chan_ok && chs == CHW'(c) &&
                idx == `ITR_CMD && i_avs_byteenable[1] && !f_busy[c]) begin
                f_start[c] = 1'b1;
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_func
        itr_func #(
            .CYCLES(FUNC_CYCLES)
        ) u_func (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_start(f_start[g]),
            .i_fnum(i_avs_writedata[15:8]),
            .i_param(f_param[g]),
            .o_busy(f_busy[g]),
            .o_done(f_done[g]),
            .o_result(f_res[g]),
            .o_clr_diag(f_clr[g])
        );
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    logic [15:0] rd_chan;
    logic [31:0] rd_word;

    always_comb begin
        rd_chan = 16'h0000;
        rd_word = 32'h0000_0000;
        if (glob) begin
            case (idx)
                `ITR_G_STATUS: rd_word = 32'(q.irq_sts);
                `ITR_G_ENABLE: rd_word = 32'(q.irq_en);
                default: rd_word = 32'h0000_0000;
            endcase
        end else if (chan_ok) begin
            for (int c = 0; c < NCH; c++) begin
                if (chs == CHW'(c)) begin
                    if (idx <= `ITR_PV_LAST) begin
                        rd_chan = q.ch[c].pv[idx[2:0]];
                    end else begin
                        case (idx)
                            `ITR_DIAG: rd_chan = q.ch[c].diag;
                            `ITR_CMD: begin
                                // Number reads back only once finished.
                                rd_chan = {q.ch[c].cmd_done ? q.ch[c].cmd_fnum
                                                            : 8'h00,
                                           q.ch[c].cmd_result};
                            end
                            `ITR_KIND: rd_chan = TERM_KIND;
                            `ITR_FWVER: rd_chan = FW_VERSION;
                            `ITR_SRLEN: rd_chan = SR_LEN;
                            `ITR_SIGCH: rd_chan = SIG_CH;
                            `ITR_MINLEN: rd_chan = MIN_LEN;
                            `ITR_DTYPE: rd_chan = {8'h00, DATA_TYPE};
                            `ITR_ALIGN: rd_chan = q.ch[c].align;
                            // Spare, manufacturer, user and extended words
                            // carry no content in this build.
                            default: rd_chan = 16'h0000;
                        endcase
                    end
                end
            end
            rd_word = {16'h0000, rd_chan};
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic [IW-1:0] irq_clr;
    logic [IW-1:0] irq_set;

    always_comb begin
        d = q;
        irq_clr = '0;
        irq_set = '0;

        // Answer one cycle after the request appears, then raise waitrequest again.
        d.wait_r = 1'b1;
        if (req && q.wait_r) begin
            d.wait_r = 1'b0;
        end
        if (i_avs_read && q.wait_r) begin
            d.rdata = rd_word;
        end

        // Software writes; read-only words simply ignore them.
        if (wr_done && glob) begin
            case (idx)
                `ITR_G_ENABLE: d.irq_en = merge_en(q.irq_en);
                `ITR_G_CLEAR: irq_clr = i_avs_writedata[IW-1:0];
                default: ;
            endcase
        end else if (wr_done && chan_ok) begin
            for (int c = 0; c < NCH; c++) begin
                if (chs == CHW'(c)) begin
                    if (idx <= `ITR_PV_LAST) begin
                        d.ch[c].pv[idx[2:0]] = merge16(q.ch[c].pv[idx[2:0]],
                                                       i_avs_writedata,
                                                       i_avs_byteenable);
                    end else if (idx == `ITR_ALIGN) begin
                        d.ch[c].align = merge16(q.ch[c].align, i_avs_writedata,
                                                i_avs_byteenable);
                    end else if (idx == `ITR_CMD && !f_busy[c]) begin
                        if (i_avs_byteenable[0]) begin
                            d.ch[c].cmd_param = i_avs_writedata[7:0];
                        end
                        if (i_avs_byteenable[1]) begin
                            d.ch[c].cmd_fnum = i_avs_writedata[15:8];
                            d.ch[c].cmd_done = 1'b0;
                        end
                    end
                    // Type words 8..15 other than alignment drop writes.
                end
            end
        end

        // Hardware events come last so that they win over any clear.
        for (int c = 0; c < NCH; c++) begin
            if (f_clr[c]) begin
                d.ch[c].diag[`ITR_DIAG_PARITY] = 1'b0;
            end
            if (i_parity_err[c]) begin
                d.ch[c].diag[`ITR_DIAG_PARITY] = 1'b1;
                irq_set[c] = 1'b1;
            end
            if (f_done[c]) begin
                d.ch[c].cmd_result = f_res[c];
                d.ch[c].cmd_done = 1'b1;
                irq_set[NCH + c] = 1'b1;
            end
        end

        d.busy = f_busy | f_start;
        d.irq_sts = (q.irq_sts & ~irq_clr) | irq_set;
        d.irq = |(d.irq_sts & d.irq_en);
    end

    function automatic logic [IW-1:0] merge_en(
        input logic [IW-1:0] old
    );
        logic [31:0] r;
        r = 32'(old);
        for (int b = 0; b < 4; b++) begin
            if (i_avs_byteenable[b]) begin
                r[8*b +: 8] = i_avs_writedata[8*b +: 8];
            end
        end
        return r[IW-1:0];
    endfunction : merge_en

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
            q.wait_r <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_avs_readdata = q.rdata;
    assign o_avs_waitrequest = q.wait_r;
    assign o_chan_busy = q.busy;
    assign o_irq = q.irq;

endmodule : itr_regs

// ### itr_regs_asserts.sv
// Checker of the register set's bus handshake, fixed words and command timing.
// Assumes binding to itr_regs with FUNC_CYCLES at 4 and sees only its ports.
`timescale 1ns/1ps
module itr_regs_asserts #(
    parameter int unsigned NCH = 1,
    parameter int unsigned CHW = 1,
    parameter logic [15:0] TERM_KIND = 16'h0000,
    parameter itr_pkg::itr_dtype_t DATA_TYPE = itr_pkg::ITR_DT_NONE,
    parameter int unsigned FUNC_CYCLES = 4
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [CHW+8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [NCH-1:0] i_parity_err,
    input wire logic [NCH-1:0] o_chan_busy,
    input wire logic o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    logic rd_done;
    logic wr_done;
    logic [5:0] widx;
    logic cmd_wr0;
    assign widx = i_avs_address[7:2];
    assign cmd_wr0 = wr_done && widx == 6'h07 && i_avs_byteenable[1]
        && !i_avs_address[CHW+8] && i_avs_address[CHW+7:8] == '0;
    assign wr_done = i_avs_write && !o_avs_waitrequest;
    assign rd_done = i_avs_read && !o_avs_waitrequest && !i_avs_address[CHW+8]
        && (i_avs_address[CHW+7:8] < NCH);
    // ********
    // Command run: the repetition count is FUNC_CYCLES plus one, spelled out.
    // ********
    sequence s_cmd_write;
        cmd_wr0;
    endsequence
    sequence s_busy_run;
        o_chan_busy[0] [*5] ##1 !o_chan_busy[0];
    endsequence
    a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("transfer not answered after one wait cycle");
    a_wait_single_low: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
        else $error("waitrequest dropped without a request");
    a_kind_word_read: assert property (rd_done && widx == 6'h08
        |-> o_avs_readdata == {16'h0000, TERM_KIND}) else $error("terminal kind word wrong");
    a_dtype_word_read: assert property (rd_done && widx == 6'h0D
        |-> o_avs_readdata == {24'h000000, DATA_TYPE}) else $error("data type word wrong");
    a_outer_area_zero: assert property (rd_done && widx >= 6'h10
        |-> o_avs_readdata == 32'h00000000) else $error("parameter area read not zero");
    a_upper_half_zero: assert property (rd_done |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("channel word upper half not zero");
    a_busy_from_cmd: assert property ($rose(o_chan_busy[0]) |-> $past(cmd_wr0))
        else $error("channel busy without command write");
    a_cmd_starts_run: assert property ((s_cmd_write ##0 !o_chan_busy[0]) |=> s_busy_run)
        else $error("command write to an idle channel did not run");
    a_busy_length: assert property ($rose(o_chan_busy[0]) |-> s_busy_run)
        else $error("function run length wrong");
    a_irq_fall_write: assert property ($fell(o_irq) |-> $past(wr_done))
        else $error("interrupt dropped without a register write");
endmodule : itr_regs_asserts

bind itr_regs itr_regs_asserts #(.NCH(NCH), .CHW(CHW), .TERM_KIND(TERM_KIND),
    .DATA_TYPE(DATA_TYPE), .FUNC_CYCLES(FUNC_CYCLES)) u_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_parity_err(i_parity_err),
    .o_chan_busy(o_chan_busy), .o_irq(o_irq));
